// >>> inc/csmh_pkg.sv
// Package for the contact sensor measure and hold block.
// Assumes a 100 MHz clock; values are signed 0.1 um counts (mm * 10000).
package csmh_pkg;

  // ********************************
  // Timing
  // ********************************
  localparam int          CLK_MHZ          = 100;
  localparam int          KEY_HOLD_MS      = 2000;
  localparam int          KEY_HOLD_CYC     = KEY_HOLD_MS * 1000 * CLK_MHZ;
  localparam int          MS_CYC           = 1000 * CLK_MHZ;

  // ********************************
  // Register offsets (byte addresses)
  // ********************************
  localparam logic [11:0] CTRL_OFS         = 12'h000;
  localparam logic [11:0] UPPER_OFS        = 12'h004;
  localparam logic [11:0] LOWER_OFS        = 12'h008;
  localparam logic [11:0] SELF_LVL_OFS     = 12'h00C;
  localparam logic [11:0] STATUS_OFS       = 12'h010;
  localparam logic [11:0] VALUE_OFS        = 12'h014;

  // ********************************
  // Reset values
  // ********************************
  localparam logic [31:0] SELF_LVL_RST     = 32'h0000_1388;
  localparam logic [31:0] UPPER_RST        = 32'h0000_2710;
  localparam logic [31:0] LOWER_RST        = 32'hFFFF_D8F0;
  localparam logic [31:0] SELF_LVL_MAX     = 32'h001E_847F;
  localparam logic [2:0]  RESP_RST         = 3'h3;

  // ********************************
  // Control register field positions
  // ********************************
  localparam int          CTRL_DET_LSB     = 0;
  localparam int          CTRL_UPD_BIT     = 3;
  localparam int          CTRL_RESP_LSB    = 4;
  localparam int          CTRL_TIM_LSB     = 7;
  localparam int          CTRL_HEAD_BIT    = 9;
  localparam int          CTRL_COMBINED_CALCULATION_BIT    = 10;
  localparam int          CTRL_REFD_BIT    = 11;
  localparam int          CTRL_EXP_BIT     = 12;

  typedef enum logic [2:0] {DET_STD, DET_NG, DET_PEAK, DET_BOTTOM, DET_P2P} csmh_det_e;
  typedef enum logic [1:0] {TIM_EXT, TIM_RISE, TIM_FALL} csmh_tim_e;

  // Settings as one carrier
  typedef struct packed {
    csmh_det_e   det;
    logic        regular_upd;
    logic [2:0]  response_time_setting;
    csmh_tim_e   tim;
    logic        head_other;
    logic        combined_calculation;
    logic        reference_difference_method;
    logic        expansion;
  } csmh_cfg_s;

  // Averaging per response choice: sample count and update period in ms
  function automatic logic [9:0] avg_count(input logic [2:0] sel);
    case (sel)
      3'h0:    avg_count = 10'h001;
      3'h1:    avg_count = 10'h003;
      3'h2:    avg_count = 10'h008;
      3'h3:    avg_count = 10'h05E;
      3'h4:    avg_count = 10'h1E0;
      default: avg_count = 10'h3C0;
    endcase
  endfunction : avg_count

  function automatic logic [7:0] upd_ms(input logic [2:0] sel, input logic other);
    logic [7:0] base;
    base = 8'h01;
    case (sel)
      3'h3:    base = 8'h04;
      3'h4:    base = 8'h10;
      3'h5:    base = 8'h20;
      default: base = 8'h01;
    endcase
    upd_ms = other ? 8'(base << 2) : base;
  endfunction : upd_ms

endpackage : csmh_pkg

// >>> core/csmh_avg.sv
// Averager: sums a programmable number of samples, divides, outputs.
// Assumes samples arrive as one-cycle strobes on the same clock.
`timescale 1ns/1ps
module csmh_avg #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // Samples in
  input  wire logic                smp_vld,
  input  wire logic signed [W-1:0] smp,
  input  wire logic [9:0]          count,
  // Average out
  output logic                     avg_vld,
  output logic signed [W-1:0]      avg
);

  logic signed [W+9:0] acc, next_acc;
  logic [9:0]          n, next_n;
  logic                next_vld;
  logic signed [W-1:0] next_avg;

  // Accumulate a window, then emit the mean; longer windows smooth more.
  // Divide by what was summed: a count shortened mid-window must not scale up.
  always_comb begin
    next_acc = acc;
    next_n   = n;
    next_vld = 1'b0;
    next_avg = avg;
    if (smp_vld) begin
      if (n + 10'h001 >= count) begin
        next_avg = W'((acc + (W+10)'(smp)) / $signed({1'b0, n + 10'h001}));
        next_vld = 1'b1;
        next_acc = '0;
        next_n   = '0;
      end else begin
        next_acc = acc + (W+10)'(smp);
        next_n   = n + 10'h001;
      end
    end
  end

  // Register stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc     <= '0;
      n       <= '0;
      avg_vld <= 1'b0;
      avg     <= '0;
    end else begin
      acc     <= next_acc;
      n       <= next_n;
      avg_vld <= next_vld;
      avg     <= next_avg;
    end
  end

endmodule : csmh_avg

// >>> core/csmh_top.sv
// Measure and hold core of a contact displacement sensor amplifier.
// Assumes samples come from head logic on clk; keys and timing are pins.
//
// Overview of operation
// - Settings entry after two-second mode hold
// - Exit on mode hold or completion-right press
// - Expansion refuses entry under combined calculation unless reference difference method is set
// - Standard mode tracks live, freezes on timing
// - Out-of-limit hold latches judgement in window
// - Peak hold keeps window maximum
// - Bottom hold keeps window minimum
// - Peak-to-peak keeps max minus min
// - Update method only for hold modes
// - Timing-input update shows result after window
// - Regular update refreshes running hold periodically
// - Standard head response and averaging table
// - Other head response and averaging table
// - Value is average of samples
// - Timing type only for standard, peak, bottom
// - Rising self-timing on upward level crossing
// - Falling self-timing on downward level crossing
// - Self-timing level signed, default 0.5000
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
module csmh_top #(
  parameter int W            = 32,
  parameter int KEY_HOLD_CYC = csmh_pkg::KEY_HOLD_CYC,
  parameter int MS_CYC       = csmh_pkg::MS_CYC,
  parameter int COMPLETE_IDX = 8
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Sensor head samples
  input  wire logic                smp_vld,
  input  wire logic signed [W-1:0] smp,
  // Pins
  input  wire logic                timing_pin,
  input  wire logic                mode_key,
  input  wire logic                right_key,
  // Results
  output logic signed [W-1:0]      disp_value,
  output logic                     judge_hi,
  output logic                     judge_lo,
  output logic                     settings_mode
);

  // ************************************
  // Pin synchronisers
  // ************************************
  logic [1:0] s_tim, s_mode, s_right;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_tim   <= 2'h0;
      s_mode  <= 2'h0;
      s_right <= 2'h0;
    end else begin
      s_tim   <= {s_tim[0], timing_pin};
      s_mode  <= {s_mode[0], mode_key};
      s_right <= {s_right[0], right_key};
    end
  end
  wire logic tim_in = s_tim[1];
  wire logic mode_in = s_mode[1];
  wire logic right_in = s_right[1];

  // ************************************
  // Registers
  // ************************************
  csmh_pkg::csmh_cfg_s cfg, next_cfg;
  logic signed [W-1:0] upper, next_upper, lower, next_lower, lvl, next_lvl;
  logic signed [W-1:0] meas;
  logic                meas_vld;

  wire logic wr = psel && penable && pwrite;
  wire logic holdm = cfg.det inside {csmh_pkg::DET_PEAK, csmh_pkg::DET_BOTTOM,
                                     csmh_pkg::DET_P2P};
  wire logic timm = cfg.det inside {csmh_pkg::DET_STD, csmh_pkg::DET_PEAK,
                                    csmh_pkg::DET_BOTTOM};

  // Writes; update method and timing type only accepted in their modes
  always_comb begin
    next_cfg   = cfg;
    next_upper = upper;
    next_lower = lower;
    next_lvl   = lvl;
    if (wr && paddr == csmh_pkg::CTRL_OFS) begin
      if (pwdata[csmh_pkg::CTRL_DET_LSB +: 3] <= 3'h4)
        next_cfg.det = csmh_pkg::csmh_det_e'(pwdata[csmh_pkg::CTRL_DET_LSB +: 3]);
      if (holdm)
        next_cfg.regular_upd = pwdata[csmh_pkg::CTRL_UPD_BIT];
      if (pwdata[csmh_pkg::CTRL_RESP_LSB +: 3] <= 3'h5)
        next_cfg.response_time_setting = pwdata[csmh_pkg::CTRL_RESP_LSB +: 3];
      if (timm && pwdata[csmh_pkg::CTRL_TIM_LSB +: 2] <= 2'h2)
        next_cfg.tim = csmh_pkg::csmh_tim_e'(pwdata[csmh_pkg::CTRL_TIM_LSB +: 2]);
      next_cfg.head_other = pwdata[csmh_pkg::CTRL_HEAD_BIT];
      next_cfg.combined_calculation = pwdata[csmh_pkg::CTRL_COMBINED_CALCULATION_BIT];
      next_cfg.reference_difference_method = pwdata[csmh_pkg::CTRL_REFD_BIT];
      next_cfg.expansion = pwdata[csmh_pkg::CTRL_EXP_BIT];
    end
    if (wr && paddr == csmh_pkg::UPPER_OFS) next_upper = W'(pwdata);
    if (wr && paddr == csmh_pkg::LOWER_OFS) next_lower = W'(pwdata);
    // Level writes outside +/-199.9999 mm are ignored
    if (wr && paddr == csmh_pkg::SELF_LVL_OFS &&
        $signed(pwdata) <= $signed(csmh_pkg::SELF_LVL_MAX) &&
        $signed(pwdata) >= -$signed(csmh_pkg::SELF_LVL_MAX))
      next_lvl = W'(pwdata);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg       <= '{det: csmh_pkg::DET_STD, regular_upd: 1'b0,
                     response_time_setting: csmh_pkg::RESP_RST,
                     tim: csmh_pkg::TIM_EXT, default: 1'b0};
      upper     <= W'(csmh_pkg::UPPER_RST);
      lower     <= W'(csmh_pkg::LOWER_RST);
      lvl       <= W'(csmh_pkg::SELF_LVL_RST);
    end else begin
      cfg       <= next_cfg;
      upper     <= next_upper;
      lower     <= next_lower;
      lvl       <= next_lvl;
    end
  end

  // APB read answers in the access cycle; unmapped reads zero with error
  always_comb begin
    pready  = 1'b1;
    pslverr = 1'b0;
    prdata  = 32'h0000_0000;
    case (paddr)
      csmh_pkg::CTRL_OFS:     prdata = 32'(cfg);
      csmh_pkg::UPPER_OFS:    prdata = 32'(upper);
      csmh_pkg::LOWER_OFS:    prdata = 32'(lower);
      csmh_pkg::SELF_LVL_OFS: prdata = 32'(lvl);
      csmh_pkg::STATUS_OFS:   prdata = {29'h0, settings_mode, judge_lo, judge_hi};
      csmh_pkg::VALUE_OFS:    prdata = 32'(meas);
      default:                pslverr = psel && penable;
    endcase
  end

  // ************************************
  // Averaging
  // ************************************
  csmh_avg #(.W(W)) u_avg (
    .clk     (clk),
    .rst     (rst),
    .smp_vld (smp_vld),
    .smp     (smp),
    .count   (csmh_pkg::avg_count(cfg.response_time_setting)),
    .avg_vld (meas_vld),
    .avg     (meas)
  );

  // ************************************
  // Timing window
  // ************************************
  logic above, next_above, win, next_win, win_q;
  always_comb begin
    next_above = above;
    if (meas_vld) next_above = meas > lvl;
    next_win = win;
    case (cfg.tim)
      csmh_pkg::TIM_EXT:  next_win = tim_in;
      csmh_pkg::TIM_RISE: if (meas_vld && !above && meas > lvl) next_win = ~win;
      csmh_pkg::TIM_FALL: if (meas_vld && above && meas <= lvl) next_win = ~win;
      default:            next_win = tim_in;
    endcase
    if (!timm) next_win = tim_in;
  end
  wire logic win_start = win && !win_q;
  wire logic win_end = !win && win_q;

  // ************************************
  // Detection
  // ************************************
  logic signed [W-1:0] pk, next_pk, bt, next_bt, next_disp;
  logic                next_hi, next_lo;
  logic [26:0]         ucnt, next_ucnt;
  wire logic [26:0] upd_cyc = 27'(csmh_pkg::upd_ms(cfg.response_time_setting,
                                                cfg.head_other) * MS_CYC);
  wire logic signed [W-1:0] runv =
    cfg.det == csmh_pkg::DET_PEAK ? pk :
    cfg.det == csmh_pkg::DET_BOTTOM ? bt : W'(pk - bt);

  always_comb begin
    next_pk   = pk;
    next_bt   = bt;
    next_disp = disp_value;
    next_hi   = judge_hi;
    next_lo   = judge_lo;
    next_ucnt = (ucnt + 27'h1 >= upd_cyc) ? 27'h0 : ucnt + 27'h1;
    if (win_start) begin
      next_pk = meas;
      next_bt = meas;
    end else if (win && meas_vld) begin
      if (meas > pk) next_pk = meas;
      if (meas < bt) next_bt = meas;
    end
    case (cfg.det)
      csmh_pkg::DET_STD: begin
        if (!win && meas_vld) begin
          next_disp = meas;
          next_hi   = meas > upper;
          next_lo   = meas < lower;
        end
      end
      csmh_pkg::DET_NG: begin
        next_disp = meas;
        // A sample arriving on the opening edge already counts (set wins)
        if (win_start) begin
          next_hi = meas_vld && (meas > upper);
          next_lo = meas_vld && (meas < lower);
        end else if (win && meas_vld) begin
          next_hi = judge_hi | (meas > upper);
          next_lo = judge_lo | (meas < lower);
        end
      end
      default: begin
        if (win_end) next_disp = runv;
        else if (win && cfg.regular_upd && ucnt == 27'h0) next_disp = runv;
        next_hi = next_disp > upper;
        next_lo = next_disp < lower;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      above      <= 1'b0;
      win        <= 1'b0;
      win_q      <= 1'b0;
      pk         <= '0;
      bt         <= '0;
      disp_value <= '0;
      judge_hi   <= 1'b0;
      judge_lo   <= 1'b0;
      ucnt       <= 27'h0;
    end else begin
      above      <= next_above;
      win        <= next_win;
      win_q      <= win;
      pk         <= next_pk;
      bt         <= next_bt;
      disp_value <= next_disp;
      judge_hi   <= next_hi;
      judge_lo   <= next_lo;
      ucnt       <= next_ucnt;
    end
  end

  // ************************************
  // Settings mode entry and exit
  // ************************************
  logic [31:0] hcnt, next_hcnt;
  logic [4:0]  item, next_item;
  logic        next_sm, r_q, next_rq, held, next_held;
  wire logic refuse = cfg.expansion && cfg.combined_calculation &&
                      !cfg.reference_difference_method;
  always_comb begin
    next_hcnt = mode_in ? hcnt + 32'h1 : 32'h0;
    next_held = mode_in ? held : 1'b0;
    next_sm   = settings_mode;
    next_item = item;
    next_rq   = right_in;
    // Hold fires once per press; release needed to toggle again
    if (mode_in && !held && hcnt + 32'h1 >= 32'(KEY_HOLD_CYC)) begin
      next_held = 1'b1;
      if (settings_mode) next_sm = 1'b0;
      else if (!refuse) next_sm = 1'b1;
      next_item = 5'h0;
    end
    if (settings_mode && right_in && !r_q) begin
      if (item == 5'(COMPLETE_IDX)) next_sm = 1'b0;
      else next_item = item + 5'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hcnt          <= 32'h0;
      held          <= 1'b0;
      settings_mode <= 1'b0;
      item          <= 5'h0;
      r_q           <= 1'b0;
    end else begin
      hcnt          <= next_hcnt;
      held          <= next_held;
      settings_mode <= next_sm;
      item          <= next_item;
      r_q           <= next_rq;
    end
  end

  // ************************************
  // Checks
  // ************************************
  sequence refused_hold_s;
    refuse && !settings_mode && mode_in && !held && hcnt + 32'h1 >= 32'(KEY_HOLD_CYC);
  endsequence
  entry_refused_a: assert property (@(posedge clk) disable iff (rst)
    refused_hold_s |=> !settings_mode) else $error("entry not refused");
  entry_hold_a: assert property (@(posedge clk) disable iff (rst)
    $rose(settings_mode) |-> $past(hcnt) + 32'h1 >= 32'(KEY_HOLD_CYC))
    else $error("entry without hold");
  peak_max_a: assert property (@(posedge clk) disable iff (rst)
    win && !win_start && $past(win) && meas_vld |=> pk >= $past(meas))
    else $error("peak below sample");
  bottom_min_a: assert property (@(posedge clk) disable iff (rst)
    win && !win_start && $past(win) && meas_vld |=> bt <= $past(meas))
    else $error("bottom above sample");
  ng_latch_a: assert property (@(posedge clk) disable iff (rst)
    cfg.det == csmh_pkg::DET_NG && judge_hi && win && !win_start && $stable(cfg) |=> judge_hi)
    else $error("ng judgement dropped");
  std_freeze_a: assert property (@(posedge clk) disable iff (rst)
    cfg.det == csmh_pkg::DET_STD && win && $stable(cfg) |=> $stable(disp_value))
    else $error("standard not frozen");
  hold_freeze_a: assert property (@(posedge clk) disable iff (rst)
    holdm && !cfg.regular_upd && win && $past(win) && $stable(cfg)
      |-> $stable(disp_value)) else $error("hold updated in window");
  win_clear_a: assert property (@(posedge clk) disable iff (rst)
    win_start |=> pk == $past(meas) && bt == $past(meas))
    else $error("accumulator not cleared");

endmodule : csmh_top

// >>> tb/csmh_head_model.sv
// Partner model: sensor head sampler and external timing source.
// Assumes the bench sets head_val and tim_req just after a clock edge.
`timescale 1ns/1ps
module csmh_head_model #(
  parameter int SMP_CYC = 4
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // Bench controls
  input  wire logic signed [31:0] head_val,
  input  wire logic               tim_req,
  // Toward the block
  output logic                    smp_vld,
  output logic signed [31:0]      smp,
  output logic                    timing_pin
);
  // ********************************
  // Sampling and timing
  // ********************************
  int                 cnt;
  logic signed [31:0] last;

  // One strobe a period; between strobes the bus shows junk, never the old value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt        <= 0;
      smp_vld    <= 1'b0;
      smp        <= 32'h0000_0000;
      last       <= 32'h0000_0000;
      timing_pin <= 1'b0;
    end else begin
      timing_pin <= tim_req;
      if (cnt == SMP_CYC - 1) begin
        cnt     <= 0;
        smp_vld <= 1'b1;
        smp     <= head_val;
        last    <= head_val;
      end else begin
        cnt     <= cnt + 1;
        smp_vld <= 1'b0;
        smp     <= ~last;
      end
    end
  end
endmodule : csmh_head_model

// >>> tb/test_contact_sensor_measure_hold.sv
// Self-checking bench for the measure and hold core over APB.
// Assumes the head model feeds samples; keys are driven here.
`timescale 1ns/1ps
module test_contact_sensor_measure_hold;
  logic               clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]        paddr = 12'h000;
  logic [31:0]        pwdata = 32'h0000_0000, prdata, hold0;
  logic               pready, pslverr, smp_vld, timing_pin, judge_hi, judge_lo, settings_mode;
  logic               mode_key = 1'b0, right_key = 1'b0, tim_req = 1'b0, err;
  logic signed [31:0] head_val = 32'h0000_0000, smp, disp_value;
  int                 bad_count = 0, checked = 0;
  logic [31:0]        hold_a [3] = '{32'h0000_01F4, 32'hFFFF_FF9C, 32'h0000_0258};
  logic [31:0]        hold_b [3] = '{32'h0000_012C, 32'h0000_00C8, 32'h0000_0064};

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  // Short key hold and millisecond so the run stays brief
  csmh_top #(.KEY_HOLD_CYC(20), .MS_CYC(4), .COMPLETE_IDX(8)) u_csmh_top (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .smp_vld(smp_vld), .smp(smp), .timing_pin(timing_pin), .mode_key(mode_key),
    .right_key(right_key), .disp_value(disp_value), .judge_hi(judge_hi),
    .judge_lo(judge_lo), .settings_mode(settings_mode));

  csmh_head_model #(.SMP_CYC(4)) u_csmh_head_model (
    .clk(clk), .rst(rst), .head_val(head_val), .tim_req(tim_req),
    .smp_vld(smp_vld), .smp(smp), .timing_pin(timing_pin));

  // ********************************
  // Helpers
  // ********************************
  task automatic results;
    if (bad_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic give_up(input string what);
    bad_count++;
    $display("CHECK FAILED %s expected done seen timeout", what);
    results();
  endtask : give_up

  // Write layout: det, update bit, response, timing, {exp, refd, combined_calculation, head}
  function automatic logic [31:0] ctl(input logic [2:0] d, input logic u, input logic [2:0] r,
                                      input logic [1:0] t, input logic [3:0] f);
    ctl = {19'h0, f, t, r, u, d};
  endfunction : ctl

  // Read layout packs the same fields in the opposite order
  function automatic logic [31:0] rb(input logic [31:0] w);
    rb = {19'h0, w[2:0], w[3], w[6:4], w[8:7], w[9], w[10], w[11], w[12]};
  endfunction : rb

  // One APB transfer; idle edge after it so the next setup never collides
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) give_up("pready");
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q, err);
  endtask : wr

  task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0000_0000, q, err);
    chk(what, q, exp);
  endtask : rdc

  // Written twice so a field judged on the old mode sees the new one
  task automatic set_ctl(input logic [31:0] w);
    wr(csmh_pkg::CTRL_OFS, w);
    wr(csmh_pkg::CTRL_OFS, w);
  endtask : set_ctl

  // Two edges first: a strobe seen earlier may still carry the old value
  task automatic feeds(input int vs[$]);
    int n;
    foreach (vs[i]) begin
      head_val <= vs[i];
      repeat (2) @(posedge clk);
      n = 0;
      while (smp_vld !== 1'b1 && n < 40) begin
        @(posedge clk);
        n++;
      end
      if (smp_vld !== 1'b1) give_up("sample");
    end
  endtask : feeds

  task automatic wait_disp(input string what, input logic [31:0] exp);
    int n;
    n = 0;
    while (disp_value !== exp && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (disp_value !== exp) give_up(what);
    chk(what, disp_value, exp);
  endtask : wait_disp

  task automatic win(input logic v);
    tim_req <= v;
    repeat (4) @(posedge clk);
  endtask : win

  task automatic press_mode(input int cyc);
    mode_key <= 1'b1;
    repeat (cyc) @(posedge clk);
    mode_key <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : press_mode

  task automatic press_right;
    right_key <= 1'b1;
    repeat (4) @(posedge clk);
    right_key <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : press_right

  task automatic do_reset;
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask : do_reset

  // ********************************
  // Main sequence
  // ********************************
  initial begin
    do_reset();
    rdc("ctrl", csmh_pkg::CTRL_OFS, rb(ctl(3'h0, 1'b0, 3'h3, 2'h0, 4'h0)));
    rdc("upper", csmh_pkg::UPPER_OFS, csmh_pkg::UPPER_RST);
    rdc("lower", csmh_pkg::LOWER_OFS, csmh_pkg::LOWER_RST);
    rdc("level", csmh_pkg::SELF_LVL_OFS, 32'h0000_1388);
    rdc("unmapped", 12'h018, 32'h0000_0000);
    chk("slverr", {31'h0, err}, 32'h0000_0001);
    // Settings the current mode does not offer are dropped
    set_ctl(ctl(3'h4, 1'b0, 3'h0, 2'h0, 4'h0));
    wr(csmh_pkg::CTRL_OFS, ctl(3'h4, 1'b0, 3'h0, 2'h1, 4'h0));
    rdc("tim_p2p", csmh_pkg::CTRL_OFS, rb(ctl(3'h4, 1'b0, 3'h0, 2'h0, 4'h0)));
    set_ctl(ctl(3'h0, 1'b0, 3'h0, 2'h0, 4'h0));
    wr(csmh_pkg::CTRL_OFS, ctl(3'h0, 1'b1, 3'h0, 2'h0, 4'h0));
    rdc("upd_std", csmh_pkg::CTRL_OFS, rb(ctl(3'h0, 1'b0, 3'h0, 2'h0, 4'h0)));
    wr(csmh_pkg::SELF_LVL_OFS, 32'hFFE1_7B81);
    wr(csmh_pkg::SELF_LVL_OFS, 32'h001E_8480);
    rdc("level_lim", csmh_pkg::SELF_LVL_OFS, 32'hFFE1_7B81);
    // Alternating samples average to the midpoint only over an even count
    set_ctl(ctl(3'h0, 1'b0, 3'h2, 2'h0, 4'h0));
    repeat (12) feeds('{100, 900});
    wait_disp("avg8", 32'h0000_01F4);
    rdc("value", csmh_pkg::VALUE_OFS, 32'h0000_01F4);
    // Standard mode follows live, freezes while timing is high
    set_ctl(ctl(3'h0, 1'b0, 3'h0, 2'h0, 4'h0));
    feeds('{1000});
    wait_disp("live", 32'h0000_03E8);
    win(1'b1);
    feeds('{15000, 15000, 15000});
    chk("frozen", disp_value, 32'h0000_03E8);
    chk("frozen_hi", {31'h0, judge_hi}, 32'h0000_0000);
    win(1'b0);
    wait_disp("thawed", 32'h0000_3A98);
    repeat (2) @(posedge clk);
    chk("thawed_hi", {31'h0, judge_hi}, 32'h0000_0001);
    // Out-of-limit excursion is latched past the window
    feeds('{0, 0});
    set_ctl(ctl(3'h1, 1'b0, 3'h0, 2'h0, 4'h0));
    win(1'b1);
    feeds('{0, 20000, -20000, 0});
    chk("ng_in", {31'h0, judge_hi}, 32'h0000_0001);
    chk("ng_in_lo", {31'h0, judge_lo}, 32'h0000_0001);
    win(1'b0);
    feeds('{0, 0});
    chk("ng_after", {31'h0, judge_hi}, 32'h0000_0001);
    win(1'b1);
    feeds('{0, 0, 0});
    chk("ng_clean", {31'h0, judge_hi}, 32'h0000_0000);
    chk("ng_clean_lo", {31'h0, judge_lo}, 32'h0000_0000);
    win(1'b0);
    // Peak, bottom, peak-to-peak; the second window must start afresh
    for (int m = 0; m < 3; m++) begin
      set_ctl(ctl(3'(m + 2), 1'b0, 3'h0, 2'h0, 4'h0));
      feeds('{200, 200});
      win(1'b1);
      hold0 = disp_value;
      feeds('{200, 500, -100});
      chk("no_update", disp_value, hold0);
      feeds('{200, 200});
      win(1'b0);
      wait_disp("hold1", hold_a[m]);
      win(1'b1);
      feeds('{200, 300, 200, 200});
      win(1'b0);
      wait_disp("hold2", hold_b[m]);
    end
    // Regular update shows the running peak inside the window
    set_ctl(ctl(3'h2, 1'b1, 3'h0, 2'h0, 4'h0));
    rdc("upd_pk", csmh_pkg::CTRL_OFS, rb(ctl(3'h2, 1'b1, 3'h0, 2'h0, 4'h0)));
    win(1'b1);
    feeds('{200, 700, 300});
    wait_disp("regular", 32'h0000_02BC);
    win(1'b0);
    // Self-timing from a clean toggle state
    do_reset();
    set_ctl(ctl(3'h2, 1'b0, 3'h0, 2'h1, 4'h0));
    feeds('{0, 0, 6000, 8000, 7000, 0, 6000, 0, 0});
    wait_disp("rise", 32'h0000_1F40);
    set_ctl(ctl(3'h3, 1'b0, 3'h0, 2'h2, 4'h0));
    feeds('{9000, 4000, -3000, 1000, 9000, 2000, 9000});
    wait_disp("fall", 32'hFFFF_F448);
    // Settings mode entry and exit by keys
    press_mode(15);
    chk("short", {31'h0, settings_mode}, 32'h0000_0000);
    press_mode(30);
    chk("enter", {31'h0, settings_mode}, 32'h0000_0001);
    rdc("status", csmh_pkg::STATUS_OFS, 32'h0000_0004);
    press_mode(30);
    chk("exit_key", {31'h0, settings_mode}, 32'h0000_0000);
    press_mode(30);
    repeat (8) press_right();
    chk("at_done", {31'h0, settings_mode}, 32'h0000_0001);
    press_right();
    chk("exit_right", {31'h0, settings_mode}, 32'h0000_0000);
    set_ctl(ctl(3'h0, 1'b0, 3'h0, 2'h0, 4'hA));
    press_mode(30);
    chk("refused", {31'h0, settings_mode}, 32'h0000_0000);
    set_ctl(ctl(3'h0, 1'b0, 3'h0, 2'h0, 4'hE));
    press_mode(30);
    chk("refd_ok", {31'h0, settings_mode}, 32'h0000_0001);
    results();
  end
endmodule : test_contact_sensor_measure_hold
